//--- dv/clie_host_model.sv
/* host processor model: avalon master that sends display instructions and data,
   splitting bytes into nibble pairs once narrow transfers are chosen.
   assumes one slave on ref_clk_i that answers each request with waitrequest low. */
`timescale 1ns/1ps
`default_nettype none
module clie_host_model (
    // clock
    input wire logic ref_clk_i,
    // avalon master
    output logic [3:0] avs_address_o,
    output logic avs_read_o,
    output logic avs_write_o,
    output logic [31:0] avs_writedata_o,
    output logic [3:0] avs_byteenable_o,
    input wire logic [31:0] avs_readdata_i,
    input wire logic avs_waitrequest_i
);
    logic narrow = 1'b0;
    logic [3:0] lane_en = 4'hF;
    initial begin
        avs_address_o = 4'h0;
        avs_read_o = 1'b0;
        avs_write_o = 1'b0;
        avs_writedata_o = 32'h00000000;
        avs_byteenable_o = 4'hF;
    end
    // one bus cycle, held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk_i);
        avs_address_o <= a;
        avs_read_o <= ~w;
        avs_write_o <= w;
        avs_writedata_o <= {24'h5A5A5A, d};
        avs_byteenable_o <= lane_en;
        @(posedge ref_clk_i);
        while (avs_waitrequest_i !== 1'b0) begin
            @(posedge ref_clk_i);
        end
        q = avs_readdata_i[7:0];
        avs_read_o <= 1'b0;
        avs_write_o <= 1'b0;
    endtask : acc
    task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [7:0] hi;
        logic [7:0] lo;
        if (narrow) begin
            acc(w, a, {d[7:4], 4'h0}, hi);
            acc(w, a, {d[3:0], 4'h0}, lo);
            q = {hi[7:4], lo[7:4]};
        end else begin
            acc(w, a, d, q);
        end
    endtask : xfer
    task automatic status(output logic [7:0] s);
        xfer(1'b0, 4'h0, 8'h00, s);
    endtask : status
    // poll until idle before any instruction or data access
    task automatic ready();
        logic [7:0] s;
        status(s);
        while (s[7] !== 1'b0) begin
            status(s);
        end
    endtask : ready
    task automatic instr(input logic [7:0] d);
        logic [7:0] q;
        ready();
        xfer(1'b1, 4'h0, d, q);
        if (d[7:5] == 3'b001) begin
            narrow = ~d[4];
        end
    endtask : instr
    task automatic wr(input logic [7:0] d);
        logic [7:0] q;
        ready();
        xfer(1'b1, 4'h4, d, q);
    endtask : wr
    // callers set an address or shift the cursor before reading
    task automatic rd(output logic [7:0] q);
        ready();
        xfer(1'b0, 4'h4, 8'h00, q);
    endtask : rd
endmodule : clie_host_model
`default_nettype wire

//--- dv/test_char_lcd_instruction_engine.sv
/* self-checking bench of the display instruction engine driven by the host model.
   assumes shortened long, blink and row counts set at the instance. */
`timescale 1ns/1ps
`default_nettype none
module test_char_lcd_instruction_engine;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [6:0] disp_addr = 7'h00;
    logic [3:0] address;
    logic rd_s;
    logic wr_s;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [31:0] rdata;
    logic wait_s;
    logic [7:0] disp_char;
    logic [15:0] commons;
    logic disp_on;
    logic cursor_dots;
    logic blink_blank;
    logic [6:0] offset;
    logic [6:0] cursor_addr;
    logic [7:0] s;
    int n_fail = 0;
    int n_checks = 0;
    clie_core #(.LONG_CYC(200), .BLINK_CYC(64), .ROW_CYC_8(8), .ROW_CYC_11(6), .ROW_CYC_16(4)) dut_u (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .avs_address_i(address), .avs_read_i(rd_s),
        .avs_write_i(wr_s), .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_s), .disp_addr_i(disp_addr), .disp_char_o(disp_char),
        .common_outputs_o(commons), .disp_on_o(disp_on), .cursor_dots_o(cursor_dots),
        .blink_blank_o(blink_blank), .disp_offset_o(offset), .cursor_addr_o(cursor_addr));
    clie_host_model host_u (
        .ref_clk_i(ref_clk_i), .avs_address_o(address), .avs_read_o(rd_s), .avs_write_o(wr_s),
        .avs_writedata_o(wdata), .avs_byteenable_o(be), .avs_readdata_i(rdata), .avs_waitrequest_i(wait_s));
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk
    task automatic ac_is(input logic [6:0] e);
        host_u.status(s);
        chk("address_counter", 16'(e), 16'(s[6:0]));
        chk("cursor_addr", 16'(e), 16'(cursor_addr));
    endtask : ac_is
    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    // two-line format, then scan reaching the last common and its row length
    task automatic t_format();
        int n;
        host_u.status(s);
        chk("busy_flag", 16'h0001, 16'(s[7]));
        host_u.instr(8'h38);
        n = 0;
        while (commons !== 16'h8000 && n < 200) begin
            n++;
            @(negedge ref_clk_i);
        end
        chk("last_common", 16'h8000, commons);
        n = 0;
        while (commons === 16'h8000 && n < 50) begin
            n++;
            @(negedge ref_clk_i);
        end
        chk("row_cycles", 16'h0004, 16'(n));
    endtask : t_format
    task automatic t_display();
        int n;
        int hits;
        host_u.instr(8'h0F);
        repeat (2) @(negedge ref_clk_i);
        chk("disp_on", 16'h0001, 16'(disp_on));
        hits = 0;
        for (n = 0; n < 80; n++) begin
            @(negedge ref_clk_i);
            if (cursor_dots === 1'b1) begin
                hits++;
                chk("cursor_row", 16'h0080, commons);
            end
        end
        chk("cursor_seen", 16'h0001, 16'(hits > 0));
        n = 0;
        while (blink_blank !== 1'b0 && n < 300) begin
            n++;
            @(negedge ref_clk_i);
        end
        while (blink_blank !== 1'b1 && n < 300) begin
            n++;
            @(negedge ref_clk_i);
        end
        n = 0;
        while (blink_blank === 1'b1 && n < 300) begin
            n++;
            @(negedge ref_clk_i);
        end
        chk("blink_half", 16'h0040, 16'(n));
    endtask : t_display
    task automatic t_write_read();
        host_u.instr(8'h07);
        host_u.instr(8'hA6);
        host_u.wr(8'h41);
        host_u.wr(8'h42);
        ac_is(7'h40);
        chk("offset", 16'h0002, 16'(offset));
        disp_addr <= 7'h26;
        repeat (3) @(negedge ref_clk_i);
        chk("text_ram", 16'h0041, 16'(disp_char));
        host_u.instr(8'hA6);
        host_u.rd(s);
        chk("read_first", 16'h0041, 16'(s));
        host_u.rd(s);
        chk("read_next", 16'h0042, 16'(s));
        ac_is(7'h40);
        chk("offset_read", 16'h0002, 16'(offset));
    endtask : t_write_read
    task automatic t_shift();
        host_u.instr(8'h18);
        ac_is(7'h40);
        chk("offset_left", 16'h0003, 16'(offset));
        host_u.instr(8'h1C);
        ac_is(7'h40);
        chk("offset_right", 16'h0002, 16'(offset));
        host_u.instr(8'h10);
        ac_is(7'h27);
        host_u.rd(s);
        chk("read_after_shift", 16'h0042, 16'(s));
        host_u.instr(8'h14);
        ac_is(7'h41);
    endtask : t_shift
    task automatic t_blank_busy();
        logic [7:0] q;
        disp_addr <= 7'h27;
        host_u.instr(8'h08);
        repeat (2) @(negedge ref_clk_i);
        chk("disp_off", 16'h0000, 16'(disp_on));
        chk("text_kept", 16'h0042, 16'(disp_char));
        host_u.instr(8'h80);
        host_u.xfer(1'b1, 4'h0, 8'h85, q);
        host_u.status(s);
        chk("busy_flag", 16'h0001, 16'(s[7]));
        host_u.ready();
        ac_is(7'h00);
        host_u.lane_en = 4'hE;
        host_u.xfer(1'b1, 4'h0, 8'h85, q);
        host_u.lane_en = 4'hF;
        ac_is(7'h00);
        host_u.acc(1'b0, 4'h8, 8'h00, q);
        chk("unmapped", 16'h0000, 16'(q));
    endtask : t_blank_busy
    task automatic t_narrow();
        host_u.instr(8'h20);
        host_u.instr(8'h85);
        ac_is(7'h05);
        host_u.instr(8'h4A);
        ac_is(7'h0A);
        host_u.wr(8'h1F);
        ac_is(7'h0B);
    endtask : t_narrow
    initial begin
        #950_000;
        n_fail++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        t_format();
        ac_is(7'h00);
        t_display();
        t_write_read();
        t_shift();
        t_blank_busy();
        t_narrow();
        test_done();
    end
endmodule : test_char_lcd_instruction_engine
`default_nettype wire

//--- rtl/clie_core.sv
/*
 * instruction decoder and executor of a character dot-matrix display controller,
 * reached over an avalon-mm slave with waitrequest, plus common-line scan timing.
 * assumes a synchronous avalon master on ref_clk_i and display drive logic
 * that reads text ram through disp_addr_i on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "clie_params.svh"

// Function
// (R1) after each ram data access, step address counter up or down by entry direction
// (R2) with shift enabled, text writes shift window left on increment, right on decrement
// (R3) data read steps the address but never shifts the display
// (R4) display enable blanks or shows the panel, text ram kept intact
// (R5) cursor draws five dots on row 8 or row 11, stepping unaffected
// (R6) blink alternates cursor character with blank every 409.6 ms
// (R7) shift command: 00 cursor left, 01 cursor right, 10 display left, 11 right
// (R8) display-only shift leaves address counter unchanged
// (R9) two-line: cursor wraps 27 to 40; shifts wrap each line within itself
// (R10) bus width bit chooses eight-bit or nibble transfers, nibbles in pairs
// (R11) format command first; later ignored unless it changes bus width
// (R12) line and font bits give 1/8, 1/11 or 1/16 duty formats
// (R13) glyph address command loads six bits and selects glyph ram
// (R14) text address command loads seven bits and selects text ram
// (R15) busy flag is set while executing; other instructions then refused
// (R16) status read returns busy flag with seven-bit address counter
// (R17) data write stores byte in selected ram, then steps and shifts
// (R18) host sets address before reading; first read otherwise stale
// (R19) cursor shift reloads the read path like a text address command
// (R20) host must not read right after a write without an address set
// (R21) scan 8, 11 or 16 commons; unused commons stay non-selected
// (R22) row lasts 400 oscillator clocks at 1/8 and 200 at 1/16
// (R23) nibble mode sends high nibble first then low, status included
// (R24) instruction decoded by the highest set data bit
module clie_core #(
    parameter int unsigned LONG_CYC = `CLIE_LONG_CYC,
    parameter int unsigned BLINK_CYC = `CLIE_BLINK_CYC,
    parameter int unsigned ROW_CYC_8 = `CLIE_ROW_OSC_8 * `CLIE_REF_PER_OSC,
    parameter int unsigned ROW_CYC_11 = `CLIE_ROW_OSC_11 * `CLIE_REF_PER_OSC,
    parameter int unsigned ROW_CYC_16 = `CLIE_ROW_OSC_16 * `CLIE_REF_PER_OSC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // avalon-mm slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // display drive side
    input wire logic [6:0] disp_addr_i,
    output logic [7:0] disp_char_o,
    output logic [15:0] common_outputs_o,
    output logic disp_on_o,
    output logic cursor_dots_o,
    output logic blink_blank_o,
    output logic [6:0] disp_offset_o,
    output logic [6:0] cursor_addr_o
);
    localparam int unsigned EXEC_CYC = `CLIE_EXEC_CYC;

    function automatic clie_pkg::clie_addr_t step_addr(input clie_pkg::clie_addr_t a, input logic up,
                                                       input logic two, input logic cg);
        clie_pkg::clie_addr_t r;
        r = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
        if (cg) begin
            r = {1'b0, r[5:0]};
        end else if (two) begin
            if (up && a == `CLIE_L1_LAST) r = `CLIE_L2_FIRST;
            else if (up && a == `CLIE_L2_LAST) r = 7'h00;
            else if (!up && a == 7'h00) r = `CLIE_L2_LAST;
            else if (!up && a == `CLIE_L2_FIRST) r = `CLIE_L1_LAST;
        end else begin
            if (up && a == `CLIE_ONE_LAST) r = 7'h00;
            else if (!up && a == 7'h00) r = `CLIE_ONE_LAST;
        end
        return r;
    endfunction : step_addr

    function automatic logic [6:0] text_index(input clie_pkg::clie_addr_t a, input logic two);
        return (two && a >= `CLIE_L2_FIRST) ? 7'(a - `CLIE_L2_FIRST + 7'(`CLIE_LINE_LEN)) : a;
    endfunction : text_index

    function automatic logic [6:0] shift_off(input logic [6:0] o, input logic left, input logic two);
        logic [6:0] last;
        last = two ? 7'(`CLIE_LINE_LEN - 1) : 7'(`CLIE_TEXT_DEPTH - 1);
        if (left) return (o >= last) ? 7'h00 : 7'(o + 7'h01);
        return (o == 7'h00 || o > last) ? last : 7'(o - 7'h01);
    endfunction : shift_off

    logic [7:0] text_ram [`CLIE_TEXT_DEPTH];
    logic [7:0] glyph_ram [`CLIE_GLYPH_DEPTH];
    clie_pkg::clie_state_e state;
    clie_pkg::clie_addr_t address_counter;
    logic [6:0] clr_ptr;
    logic [31:0] busy_cnt;
    logic sel_glyph, inc_dir, shift_en, disp_en, cur_en, blink_en;
    logic bus_width_select, two_line, tall_font, format_done;
    logic nib_phase;
    logic [3:0] hi_nib;
    logic [7:0] rd_buf;
    logic prefetch;
    logic [6:0] offset;
    logic [31:0] row_cnt, blink_cnt;
    logic [3:0] row;
    logic blink_phase;

    // bus decode
    wire busy_flag = (state == clie_pkg::CLIE_CLEARING) || (busy_cnt != 32'h0);
    wire acc = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    wire sel_ins = avs_address_i == `CLIE_OFF_INSTR;
    wire sel_dat = avs_address_i == `CLIE_OFF_DATA;
    wire mapped = sel_ins || sel_dat;
    wire complete = bus_width_select || nib_phase; // [R10] [R23]
    wire wr_ok = acc && avs_write_i && avs_byteenable_i[0] && mapped;
    wire [7:0] wbyte = bus_width_select ? avs_writedata_i[7:0] : {hi_nib, avs_writedata_i[7:4]}; // [R23]
    wire do_ins = wr_ok && sel_ins && complete && !busy_flag; // [R15]
    wire do_dat = wr_ok && sel_dat && complete && !busy_flag; // [R15]
    wire do_rd = acc && avs_read_i && sel_dat && complete && !busy_flag;
    wire [7:0] rbyte = sel_ins ? {busy_flag, address_counter} : rd_buf; // [R16]
    wire [7:0] rlane = bus_width_select ? rbyte : {(nib_phase ? rbyte[3:0] : rbyte[7:4]), 4'h0}; // [R23]
    wire [31:0] next_readdata = mapped ? {24'h0, rlane} : 32'h0;

    // instruction decode by highest set bit
    wire op_dd = do_ins && wbyte[`CLIE_OP_DDADDR]; // [R24]
    wire op_cg = do_ins && wbyte[7:6] == 2'b01; // [R24]
    wire op_fn = do_ins && wbyte[7:5] == 3'b001; // [R24]
    wire op_sh = do_ins && wbyte[7:4] == 4'b0001; // [R24]
    wire op_dc = do_ins && wbyte[7:3] == 5'b00001; // [R24]
    wire op_em = do_ins && wbyte[7:2] == 6'b000001; // [R24]
    wire op_hm = do_ins && wbyte[7:1] == 7'b0000001; // [R24]
    wire op_cl = do_ins && wbyte == 8'h01; // [R24]
    wire sh_disp = wbyte[3];
    wire sh_right = wbyte[2];
    wire fn_apply = op_fn && (!format_done || wbyte[4] != bus_width_select); // [R11]
    wire text_wr = do_dat && !sel_glyph;
    wire [6:0] wr_idx = text_index(address_counter, two_line);
    wire text_we = (state == clie_pkg::CLIE_CLEARING) || (text_wr && wr_idx < 7'(`CLIE_TEXT_DEPTH));

    // avalon handshake: one wait state, then answer
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0;
        end else begin
            avs_waitrequest_o <= !(avs_waitrequest_o && (avs_read_i || avs_write_i));
            if (avs_waitrequest_o && avs_read_i) avs_readdata_o <= next_readdata;
        end
    end

    // nibble pairing, cleared when the width changes
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            nib_phase <= 1'b0;
            hi_nib <= 4'h0;
        end else if (fn_apply || bus_width_select) begin
            nib_phase <= 1'b0;
        end else if (acc && mapped && (avs_read_i || avs_byteenable_i[0])) begin
            nib_phase <= !nib_phase; // [R23]
            if (!nib_phase) hi_nib <= avs_writedata_i[7:4];
        end
    end

    // busy timer and clear sequencer
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_cnt <= 32'h0;
            state <= clie_pkg::CLIE_CLEARING;
            clr_ptr <= 7'h00;
        end else begin
            if (op_cl || op_hm) busy_cnt <= 32'(LONG_CYC); // [R15]
            else if (do_ins || do_dat || do_rd) busy_cnt <= 32'(EXEC_CYC); // [R15]
            else if (busy_cnt != 32'h0) busy_cnt <= busy_cnt - 32'h1;
            case (state)
                clie_pkg::CLIE_RUN: begin
                    if (op_cl) state <= clie_pkg::CLIE_CLEARING;
                    clr_ptr <= 7'h00;
                end
                clie_pkg::CLIE_CLEARING: begin
                    clr_ptr <= 7'(clr_ptr + 7'h01);
                    if (clr_ptr == 7'(`CLIE_TEXT_DEPTH - 1)) state <= clie_pkg::CLIE_RUN;
                end
                default: state <= clie_pkg::CLIE_RUN;
            endcase
        end
    end

    // rams: contents never touched by display enable
    always_ff @(posedge ref_clk_i) begin
        if (text_we) text_ram[state == clie_pkg::CLIE_CLEARING ? clr_ptr : wr_idx] <=
                (state == clie_pkg::CLIE_CLEARING) ? `CLIE_SPACE_CODE : wbyte; // [R17] [R4]
        if (do_dat && sel_glyph) glyph_ram[address_counter[5:0]] <= wbyte; // [R17]
        if (prefetch) rd_buf <= sel_glyph ? glyph_ram[address_counter[5:0]] :
                text_ram[text_index(address_counter, two_line)];
        disp_char_o <= text_ram[text_index(disp_addr_i, two_line)];
    end

    // address counter, ram select and read prefetch
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            address_counter <= 7'h00;
            sel_glyph <= 1'b0;
            prefetch <= 1'b0;
        end else begin
            prefetch <= op_dd || op_cg || (op_sh && !sh_disp) || do_rd; // [R19] [R18]
            if (op_dd) begin
                address_counter <= wbyte[6:0]; // [R14]
                sel_glyph <= 1'b0;
            end else if (op_cg) begin
                address_counter <= {1'b0, wbyte[5:0]}; // [R13]
                sel_glyph <= 1'b1;
            end else if (op_cl || op_hm) begin
                address_counter <= 7'h00;
                sel_glyph <= 1'b0;
            end else if (op_sh && !sh_disp) begin
                address_counter <= step_addr(address_counter, sh_right, two_line, sel_glyph); // [R7] [R9]
            end else if (do_dat || do_rd) begin
                address_counter <= step_addr(address_counter, inc_dir, two_line, sel_glyph); // [R1] [R3] [R9]
            end
        end
    end

    // display offset: both lines move together, each within its own line
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) offset <= 7'h00;
        else if (op_cl || op_hm) offset <= 7'h00;
        else if (op_sh && sh_disp) offset <= shift_off(offset, !sh_right, two_line); // [R7] [R8] [R9]
        else if (text_wr && shift_en) offset <= shift_off(offset, inc_dir, two_line); // [R2]
    end

    // mode bits
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {inc_dir, shift_en, disp_en, cur_en, blink_en} <= 5'b10000;
            {bus_width_select, two_line, tall_font, format_done} <= 4'b1000;
        end else begin
            if (op_cl) inc_dir <= 1'b1;
            if (op_em) {inc_dir, shift_en} <= wbyte[1:0];
            if (op_dc) {disp_en, cur_en, blink_en} <= wbyte[2:0]; // [R4] [R5] [R6]
            if (fn_apply) begin
                bus_width_select <= wbyte[4]; // [R10]
                format_done <= 1'b1; // [R11]
                if (!format_done) {two_line, tall_font} <= {wbyte[3], wbyte[2] && !wbyte[3]}; // [R12]
            end
        end
    end

    // common scan and blink timing
    wire [3:0] ncom = two_line ? 4'(`CLIE_COM_16 - 1) : (tall_font ? 4'(`CLIE_COM_11 - 1) : 4'(`CLIE_COM_8 - 1));
    wire [31:0] row_len = two_line ? 32'(ROW_CYC_16) : (tall_font ? 32'(ROW_CYC_11) : 32'(ROW_CYC_8)); // [R22]
    wire row_end = row_cnt >= row_len - 32'h1;
    wire [3:0] next_row = (row >= ncom) ? 4'h0 : 4'(row + 4'h1);
    wire [3:0] cur_row = two_line ? (address_counter >= `CLIE_L2_FIRST ? 4'hF : 4'h7) : (tall_font ? 4'hA : 4'h7);

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            row_cnt <= 32'h0;
            row <= 4'h0;
        end else if (row_end) begin
            row_cnt <= 32'h0;
            row <= next_row; // [R21]
        end else begin
            row_cnt <= row_cnt + 32'h1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            blink_cnt <= 32'h0;
            blink_phase <= 1'b0;
        end else if (blink_cnt >= 32'(BLINK_CYC) - 32'h1) begin
            blink_cnt <= 32'h0;
            blink_phase <= !blink_phase; // [R6]
        end else begin
            blink_cnt <= blink_cnt + 32'h1;
        end
    end

    // outputs; an unused common stays low as its non-selection level
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            common_outputs_o <= 16'h0000;
            {disp_on_o, cursor_dots_o, blink_blank_o} <= 3'b000;
            disp_offset_o <= 7'h00;
            cursor_addr_o <= 7'h00;
        end else begin
            common_outputs_o <= (row <= ncom) ? 16'(16'h0001 << row) : 16'h0000; // [R21] [R12]
            disp_on_o <= disp_en; // [R4]
            cursor_dots_o <= disp_en && cur_en && row == cur_row; // [R5]
            blink_blank_o <= disp_en && blink_en && blink_phase; // [R6]
            disp_offset_o <= offset;
            cursor_addr_o <= address_counter;
        end
    end

    sequence ins_taken_s;
        do_ins && !op_fn;
    endsequence
    sequence held_busy_s;
        busy_flag [*8];
    endsequence

    ac_step_up_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R1]
        (do_dat && inc_dir && !sel_glyph && address_counter < `CLIE_ONE_LAST && address_counter != `CLIE_L1_LAST)
        |=> address_counter == 7'($past(address_counter) + 7'h01)) else $error("address counter did not step up");
    shift_on_write_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R2]
        (text_wr && shift_en && two_line && offset != 7'h00 && offset < 7'(`CLIE_LINE_LEN - 1))
        |=> offset == ($past(inc_dir) ? 7'($past(offset) + 7'h01) : 7'($past(offset) - 7'h01)))
        else $error("display did not shift on write");
    read_noshift_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R3]
        do_rd |=> $stable(offset)) else $error("read shifted the display");
    disp_shift_ac_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R8]
        (op_sh && sh_disp) |=> $stable(address_counter)) else $error("display shift moved address counter");
    line_wrap_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R9]
        (do_dat && inc_dir && two_line && !sel_glyph && address_counter == `CLIE_L1_LAST)
        |=> address_counter == `CLIE_L2_FIRST) else $error("cursor did not wrap to second line");
    format_lock_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R11]
        (op_fn && format_done) |=> $stable(two_line) && $stable(tall_font)) else $error("format changed after lock");
    busy_refuse_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R15]
        (wr_ok && sel_ins && busy_flag) |=> $stable(address_counter) && $stable(disp_en))
        else $error("instruction taken while busy");
    busy_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R15]
        ins_taken_s |=> held_busy_s) else $error("busy flag dropped too early");
    status_read_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R16]
        (avs_read_i && avs_waitrequest_o && sel_ins && bus_width_select)
        |=> avs_readdata_o[6:0] == $past(address_counter)) else $error("status read lost address counter");
    com_unused_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [R21]
        (!two_line && !tall_font && $stable(two_line)) |=> common_outputs_o[15:8] == 8'h00)
        else $error("unused common selected");
endmodule : clie_core
`default_nettype wire

//--- rtl/clie_params.svh
/*
 * constants of the character display instruction engine: register offsets,
 * field positions, address ranges and timing figures.
 * assumes a 100 MHz core clock and a 250 kHz display reference oscillator.
 */
`ifndef CLIE_PARAMS_SVH
`define CLIE_PARAMS_SVH

// register byte offsets on the avalon slave
`define CLIE_OFF_INSTR 4'h0
`define CLIE_OFF_DATA 4'h4

// opcode bit positions, decoded by highest set bit
`define CLIE_OP_DDADDR 7
`define CLIE_OP_CGADDR 6
`define CLIE_OP_FUNC 5
`define CLIE_OP_SHIFT 4
`define CLIE_OP_DISP 3
`define CLIE_OP_ENTRY 2
`define CLIE_OP_HOME 1
`define CLIE_OP_CLEAR 0

// address ranges of the text ram
`define CLIE_ONE_LAST 7'h4F
`define CLIE_L1_LAST 7'h27
`define CLIE_L2_FIRST 7'h40
`define CLIE_L2_LAST 7'h67
`define CLIE_TEXT_DEPTH 80
`define CLIE_LINE_LEN 40
`define CLIE_GLYPH_DEPTH 64
`define CLIE_SPACE_CODE 8'h20

// timing
`define CLIE_CLK_KHZ 100000
`define CLIE_OSC_KHZ 250
`define CLIE_REF_PER_OSC (`CLIE_CLK_KHZ / `CLIE_OSC_KHZ)
`define CLIE_EXEC_US 40
`define CLIE_EXEC_CYC (`CLIE_EXEC_US * (`CLIE_CLK_KHZ / 1000))
`define CLIE_LONG_US 1640
`define CLIE_LONG_CYC (`CLIE_LONG_US * (`CLIE_CLK_KHZ / 1000))
`define CLIE_BLINK_US 409600
`define CLIE_BLINK_CYC (`CLIE_BLINK_US * (`CLIE_CLK_KHZ / 1000))
`define CLIE_ROW_OSC_8 400
`define CLIE_ROW_OSC_11 291
`define CLIE_ROW_OSC_16 200
`define CLIE_COM_8 8
`define CLIE_COM_11 11
`define CLIE_COM_16 16

`endif

//--- rtl/clie_pkg.sv
/*
 * types of the character display instruction engine.
 * assumes nothing beyond a sv compiler.
 */
package clie_pkg;
    typedef enum logic {CLIE_RUN, CLIE_CLEARING} clie_state_e;
    typedef logic [6:0] clie_addr_t;
endpackage : clie_pkg
